//--- rtl/usc_top.sv
// serial port control register, flags and apb slave
// What this block does
// - shift mode: rx flag after eighth bit
// - eight-bit async: rx flag mid stop bit
// - nine-bit, select clear: rx flag mid ninth bit
// - nine-bit, select set: mid stop, multiproc qualified
// - hardware never clears tx or rx flag
// - shift mode: tx flag after eighth bit
// - async: tx flag at stop bit position
// - position bit: stop start or end, ignored shift
// - nine-bit modes: capture ninth data bit
// - eight-bit async: capture stop bit value
// - shift mode: ninth bit field undefined
// - select bit swaps bit 7 to framing error
//
// Local design decisions: the register offsets and register access over APB.
`default_nettype none
module usc_top
    import usc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic rx_bit8_done_in,
    input wire logic rx_ninth_mid_in,
    input wire logic rx_ninth_val_in,
    input wire logic rx_stop_mid_in,
    input wire logic rx_stop_val_in,
    input wire logic tx_bit8_done_in,
    input wire logic tx_stop_start_in,
    input wire logic tx_stop_end_in,
    output logic [1:0] mode_out,
    output logic rx_enable_out,
    output logic multiproc_enable_out,
    output logic tx_ninth_bit_out,
    output logic irq_out
);
    usc_evt_if evt ();

    logic mode_bit_low_select_ff;
    logic mode_bit_second_ff;
    logic multiproc_enable_ff;
    logic rx_enable_ff;
    logic tx_ninth_bit_ff;
    logic rx_ninth_bit_ff;
    logic tx_irq_flag_ff;
    logic rx_irq_flag_ff;
    logic framing_error_flag_ff;
    logic tx_irq_position_ff;
    logic frame_error_select_ff;
    logic [USC_IRQ_W-1:0] irq_stat_ff;
    logic [USC_IRQ_W-1:0] irq_mask_ff;
    logic [USC_IRQ_W-1:0] nxt_irq_stat;
    logic [USC_IRQ_W-1:0] irq_events;
    logic irq_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_rdata;
    logic nxt_err;
    logic wr_done;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_cfg;
    logic wr_istat;
    logic wr_imask;
    logic [7:0] ctrl_view;
    logic [7:0] stat_view;
    logic [7:0] cfg_view;

    // ************************************************************
    // event qualifiers
    // ************************************************************
    assign evt.mode = usc_mode_type'({mode_bit_low_select_ff, mode_bit_second_ff});
    assign evt.ren = rx_enable_ff;
    assign evt.mpe = multiproc_enable_ff;
    assign evt.fes = frame_error_select_ff;
    assign evt.txpos = tx_irq_position_ff;

    usc_rx_qual u_rx_qual (
        .evt(evt.rxq),
        .rx_bit8_done_in(rx_bit8_done_in),
        .rx_ninth_mid_in(rx_ninth_mid_in),
        .rx_ninth_val_in(rx_ninth_val_in),
        .rx_stop_mid_in(rx_stop_mid_in),
        .rx_stop_val_in(rx_stop_val_in)
    );

    usc_tx_evt u_tx_evt (
        .evt(evt.txe),
        .tx_bit8_done_in(tx_bit8_done_in),
        .tx_stop_start_in(tx_stop_start_in),
        .tx_stop_end_in(tx_stop_end_in)
    );

    // ************************************************************
    // apb decode
    // ************************************************************
    // one wait state; write lands on the edge where pready is seen high
    assign wr_done = psel_in && penable_in && pwrite_in && pready_ff;
    assign wr_ctrl = wr_done && (paddr_in == USC_OFS_CTRL);
    assign wr_stat = wr_done && (paddr_in == USC_OFS_STAT);
    assign wr_cfg = wr_done && (paddr_in == USC_OFS_CFG);
    assign wr_istat = wr_done && (paddr_in == USC_OFS_IRQ_STAT);
    assign wr_imask = wr_done && (paddr_in == USC_OFS_IRQ_MASK);

    always_comb
    begin
        ctrl_view = USC_RST_CTRL;
        ctrl_view[USC_BIT_MODE_LOW] = frame_error_select_ff ? framing_error_flag_ff
                                                            : mode_bit_low_select_ff;
        ctrl_view[USC_BIT_MODE_SECOND] = mode_bit_second_ff;
        ctrl_view[USC_BIT_MPE] = multiproc_enable_ff;
        ctrl_view[USC_BIT_REN] = rx_enable_ff;
        ctrl_view[USC_BIT_TB8] = tx_ninth_bit_ff;
        ctrl_view[USC_BIT_RB8] = rx_ninth_bit_ff;
        ctrl_view[USC_BIT_TI] = tx_irq_flag_ff;
        ctrl_view[USC_BIT_RI] = rx_irq_flag_ff;
        stat_view = USC_RST_STAT;
        stat_view[USC_BIT_TXPOS] = tx_irq_position_ff;
        stat_view[USC_BIT_FE_STAT] = framing_error_flag_ff;
        cfg_view = USC_RST_CFG;
        cfg_view[USC_BIT_FES] = frame_error_select_ff;
        nxt_rdata = USC_RD_ZERO;
        nxt_err = 1'b0;
        case (paddr_in)
            USC_OFS_CTRL: nxt_rdata[7:0] = ctrl_view;
            USC_OFS_STAT: nxt_rdata[7:0] = stat_view;
            USC_OFS_CFG: nxt_rdata[7:0] = cfg_view;
            USC_OFS_IRQ_STAT: nxt_rdata[USC_IRQ_W-1:0] = irq_stat_ff;
            USC_OFS_IRQ_MASK: nxt_rdata[USC_IRQ_W-1:0] = irq_mask_ff;
            default: nxt_err = 1'b1;
        endcase
    end

    // ************************************************************
    // apb handshake
    // ************************************************************
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= USC_RD_ZERO;
        end
        else
        begin
            pready_ff <= psel_in && penable_in && !pready_ff;
            pslverr_ff <= psel_in && penable_in && !pready_ff && nxt_err;
            if (psel_in && penable_in && !pready_ff && !pwrite_in)
            begin
                prdata_ff <= nxt_rdata;
            end
            else if (pready_ff)
            begin
                prdata_ff <= USC_RD_ZERO;
            end
        end
    end

    // ************************************************************
    // mode and software control bits
    // ************************************************************
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            mode_bit_low_select_ff <= USC_RST_CTRL[USC_BIT_MODE_LOW];
            mode_bit_second_ff <= USC_RST_CTRL[USC_BIT_MODE_SECOND];
            multiproc_enable_ff <= USC_RST_CTRL[USC_BIT_MPE];
            rx_enable_ff <= USC_RST_CTRL[USC_BIT_REN];
            tx_ninth_bit_ff <= USC_RST_CTRL[USC_BIT_TB8];
        end
        else if (wr_ctrl)
        begin
            // bit 7 belongs to the error flag while the select bit is set
            if (!frame_error_select_ff)
            begin
                mode_bit_low_select_ff <= pwdata_in[USC_BIT_MODE_LOW];
            end
            mode_bit_second_ff <= pwdata_in[USC_BIT_MODE_SECOND];
            multiproc_enable_ff <= pwdata_in[USC_BIT_MPE];
            rx_enable_ff <= pwdata_in[USC_BIT_REN];
            tx_ninth_bit_ff <= pwdata_in[USC_BIT_TB8];
        end
    end

    // ************************************************************
    // status and config bits
    // ************************************************************
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            tx_irq_position_ff <= USC_RST_STAT[USC_BIT_TXPOS];
            frame_error_select_ff <= USC_RST_CFG[USC_BIT_FES];
        end
        else
        begin
            if (wr_stat)
            begin
                tx_irq_position_ff <= pwdata_in[USC_BIT_TXPOS];
            end
            if (wr_cfg)
            begin
                frame_error_select_ff <= pwdata_in[USC_BIT_FES];
            end
        end
    end

    // ************************************************************
    // hardware flags: set wins over a software write
    // ************************************************************
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            tx_irq_flag_ff <= USC_RST_CTRL[USC_BIT_TI];
        end
        else if (evt.tx_set)
        begin
            // only software can drop these, hardware only sets
            tx_irq_flag_ff <= 1'b1;
        end
        else if (wr_ctrl)
        begin
            tx_irq_flag_ff <= pwdata_in[USC_BIT_TI];
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            rx_irq_flag_ff <= USC_RST_CTRL[USC_BIT_RI];
        end
        else if (evt.rx_set)
        begin
            rx_irq_flag_ff <= 1'b1;
        end
        else if (wr_ctrl)
        begin
            rx_irq_flag_ff <= pwdata_in[USC_BIT_RI];
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            framing_error_flag_ff <= 1'b0;
        end
        else if (evt.fe_set)
        begin
            framing_error_flag_ff <= 1'b1;
        end
        else if (wr_ctrl && frame_error_select_ff)
        begin
            framing_error_flag_ff <= pwdata_in[USC_BIT_MODE_LOW];
        end
    end

    // ************************************************************
    // received ninth bit
    // ************************************************************
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            rx_ninth_bit_ff <= USC_RST_CTRL[USC_BIT_RB8];
        end
        else if (evt.rb8_load)
        begin
            rx_ninth_bit_ff <= evt.rb8_val;
        end
        else if (wr_ctrl)
        begin
            rx_ninth_bit_ff <= pwdata_in[USC_BIT_RB8];
        end
    end

    // ************************************************************
    // interrupt status, mask and output
    // ************************************************************
    always_comb
    begin
        irq_events = USC_RST_IRQ;
        irq_events[USC_IRQ_RX] = evt.rx_set;
        irq_events[USC_IRQ_TX] = evt.tx_set;
        irq_events[USC_IRQ_FE] = evt.fe_set;
        nxt_irq_stat = irq_stat_ff;
        if (wr_istat)
        begin
            nxt_irq_stat = irq_stat_ff & ~pwdata_in[USC_IRQ_W-1:0];
        end
        nxt_irq_stat = nxt_irq_stat | irq_events;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            irq_stat_ff <= USC_RST_IRQ;
        end
        else
        begin
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            irq_mask_ff <= USC_RST_IRQ;
        end
        else if (wr_imask)
        begin
            irq_mask_ff <= pwdata_in[USC_IRQ_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            irq_ff <= 1'b0;
        end
        else
        begin
            // taken from the next status value, so it moves with the status bit and the pin is a flop
            irq_ff <= |(nxt_irq_stat & irq_mask_ff);
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata_out = prdata_ff;
    assign pready_out = pready_ff;
    assign pslverr_out = pslverr_ff;
    assign mode_out = {mode_bit_low_select_ff, mode_bit_second_ff};
    assign rx_enable_out = rx_enable_ff;
    assign multiproc_enable_out = multiproc_enable_ff;
    assign tx_ninth_bit_out = tx_ninth_bit_ff;
    assign irq_out = irq_ff;
endmodule // usc_top
`default_nettype wire

//--- rtl/usc_pkg.sv
// constants and types shared by the serial control and flag logic
`default_nettype none
package usc_pkg;
    // ************************************************************
    // register byte offsets on apb
    // ************************************************************
    localparam logic [7:0] USC_OFS_CTRL = 8'h00;
    localparam logic [7:0] USC_OFS_STAT = 8'h04;
    localparam logic [7:0] USC_OFS_CFG = 8'h08;
    localparam logic [7:0] USC_OFS_IRQ_STAT = 8'h0c;
    localparam logic [7:0] USC_OFS_IRQ_MASK = 8'h10;
    // ************************************************************
    // serial_port_control field positions
    // ************************************************************
    localparam int USC_BIT_MODE_LOW = 7;
    localparam int USC_BIT_MODE_SECOND = 6;
    localparam int USC_BIT_MPE = 5;
    localparam int USC_BIT_REN = 4;
    localparam int USC_BIT_TB8 = 3;
    localparam int USC_BIT_RB8 = 2;
    localparam int USC_BIT_TI = 1;
    localparam int USC_BIT_RI = 0;
    // ************************************************************
    // serial_status, config and interrupt field positions
    // ************************************************************
    localparam int USC_BIT_TXPOS = 6;
    localparam int USC_BIT_FE_STAT = 3;
    localparam int USC_BIT_FES = 6;
    localparam int USC_IRQ_RX = 0;
    localparam int USC_IRQ_TX = 1;
    localparam int USC_IRQ_FE = 2;
    localparam int USC_IRQ_W = 3;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] USC_RST_CTRL = 8'h00;
    localparam logic [7:0] USC_RST_STAT = 8'h00;
    localparam logic [7:0] USC_RST_CFG = 8'h00;
    localparam logic [2:0] USC_RST_IRQ = 3'h0;
    localparam logic [31:0] USC_RD_ZERO = 32'h00000000;
    // ************************************************************
    // operating modes
    // ************************************************************
    typedef enum logic [1:0] {
        USC_MODE_SHIFT = 2'h0,
        USC_MODE_ASYNC8 = 2'h1,
        USC_MODE_ASYNC9_FIX = 2'h2,
        USC_MODE_ASYNC9_VAR = 2'h3
    } usc_mode_type;
endpackage
`default_nettype wire

//--- rtl/usc_evt_if.sv
// configuration and event signals between control top and event qualifiers
`default_nettype none
interface usc_evt_if;
    import usc_pkg::*;
    usc_mode_type mode;
    logic ren;
    logic mpe;
    logic fes;
    logic txpos;
    logic rx_set;
    logic rb8_load;
    logic rb8_val;
    logic fe_set;
    logic tx_set;
    modport top (output mode, ren, mpe, fes, txpos,
                 input rx_set, rb8_load, rb8_val, fe_set, tx_set);
    modport rxq (input mode, ren, mpe, fes,
                 output rx_set, rb8_load, rb8_val, fe_set);
    modport txe (input mode, txpos, output tx_set);
endinterface
`default_nettype wire

//--- rtl/usc_rx_qual.sv
// receive interrupt timing, multiprocessor qualification, ninth bit capture
`default_nettype none
module usc_rx_qual
    import usc_pkg::*;
(
    usc_evt_if.rxq evt,
    input wire logic rx_bit8_done_in,
    input wire logic rx_ninth_mid_in,
    input wire logic rx_ninth_val_in,
    input wire logic rx_stop_mid_in,
    input wire logic rx_stop_val_in
);
    logic nine_point;
    logic qual_ok;
    // ************************************************************
    // event selection per mode
    // ************************************************************
    always_comb
    begin
        nine_point = evt.fes ? rx_stop_mid_in : rx_ninth_mid_in;
        qual_ok = !evt.mpe || rx_ninth_val_in;
        evt.rx_set = 1'b0;
        evt.rb8_load = 1'b0;
        evt.rb8_val = 1'b0;
        evt.fe_set = 1'b0;
        case (evt.mode)
            USC_MODE_SHIFT:
            begin
                // ninth bit left untouched, it has no meaning here
                evt.rx_set = evt.ren && rx_bit8_done_in;
            end
            USC_MODE_ASYNC8:
            begin
                // multiproc bit is assumed zero by software here
                evt.rx_set = evt.ren && rx_stop_mid_in;
                evt.rb8_load = evt.rx_set;
                evt.rb8_val = rx_stop_val_in;
                evt.fe_set = evt.ren && rx_stop_mid_in && !rx_stop_val_in;
            end
            USC_MODE_ASYNC9_FIX, USC_MODE_ASYNC9_VAR:
            begin
                evt.rx_set = evt.ren && nine_point && qual_ok;
                evt.rb8_load = evt.rx_set;
                evt.rb8_val = rx_ninth_val_in;
                evt.fe_set = evt.ren && rx_stop_mid_in && !rx_stop_val_in;
            end
            default:
            begin
                evt.rx_set = 1'b0;
            end
        endcase
    end
endmodule // usc_rx_qual
`default_nettype wire

//--- rtl/usc_tx_evt.sv
// transmit interrupt timing per mode and position setting
`default_nettype none
module usc_tx_evt
    import usc_pkg::*;
(
    usc_evt_if.txe evt,
    input wire logic tx_bit8_done_in,
    input wire logic tx_stop_start_in,
    input wire logic tx_stop_end_in
);
    // ************************************************************
    // event selection
    // ************************************************************
    always_comb
    begin
        case (evt.mode)
            // position bit ignored in shift mode so a stray one cannot move the flag
            USC_MODE_SHIFT: evt.tx_set = tx_bit8_done_in;
            default: evt.tx_set = evt.txpos ? tx_stop_end_in : tx_stop_start_in;
        endcase
    end
endmodule // usc_tx_evt
`default_nettype wire

//--- verification/usc_line_model.sv
// remote line partner: frame event pulses and sampled bit levels
`default_nettype none
module usc_line_model (
    input wire logic clk_in,
    output logic [5:0] evt_out,
    output logic ninth_val_out,
    output logic stop_val_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // frame driver
    // ************************************************************
    initial
    begin
        evt_out = 6'h00;
        ninth_val_out = 1'b0;
        stop_val_out = 1'b1;
    end
    // bits: rx bit8, rx ninth mid, rx stop mid, tx bit8, tx stop start, tx stop end
    task automatic frame(input logic [5:0] k, input logic nb, input logic sb);
        @(posedge clk_in);
        ninth_val_out <= nb;
        stop_val_out <= sb;
        for (int i = 0; i < 6; i++)
        begin
            if (k[i])
            begin
                @(posedge clk_in);
                evt_out <= 6'(6'h01 << i);
                @(posedge clk_in);
                evt_out <= 6'h00;
            end
        end
        // levels only hold through the frame's event pulses; flip them so stale use shows
        @(posedge clk_in);
        ninth_val_out <= ~nb;
        stop_val_out <= ~sb;
        @(negedge clk_in);
    endtask
endmodule // usc_line_model
`default_nettype wire

//--- verification/usc_top_properties.sv
// concurrent checks on the serial control top ports
`default_nettype none
module usc_top_properties
    import usc_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic [1:0] mode_out,
    input wire logic rx_enable_out,
    input wire logic irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // helpers and properties
    // ************************************************************
    logic fes_ff;
    logic wr_ok;
    logic ctrl_wr;
    logic sw_wr;
    assign wr_ok = psel_in && penable_in && pwrite_in && pready_out && !pslverr_out;
    assign ctrl_wr = wr_ok && (paddr_in == USC_OFS_CTRL);
    assign sw_wr = psel_in && pwrite_in;
    // mirror of the select bit, since bit 7 changes meaning with it
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            fes_ff <= 1'b0;
        else if (wr_ok && (paddr_in == USC_OFS_CFG))
            fes_ff <= pwdata_in[USC_BIT_FES];
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    a_reset_clear: assert property (disable iff (1'b0)
        rst_in |=> mode_out == 2'h0 && !rx_enable_out && !irq_out && !pready_out)
        else $error("outputs not cleared by reset");
    a_mode_write: assert property (ctrl_wr && !fes_ff |=> mode_out == $past(pwdata_in[7:6]))
        else $error("mode bits not taken from write");
    a_fe_keeps_mode: assert property (ctrl_wr && fes_ff |=> $stable(mode_out[1]))
        else $error("mode changed while bit 7 is framing error");
    a_ren_follows: assert property (ctrl_wr |=> rx_enable_out == $past(pwdata_in[4]))
        else $error("receive enable not taken from write");
    a_irq_sw_only: assert property ($fell(irq_out) |->
        $past(rst_in) || $past(sw_wr) || $past(sw_wr, 2) || $past(sw_wr, 3))
        else $error("interrupt dropped without software write");
    a_err_answer: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
        else $error("error response malformed");
    a_ready_once: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    a_ready_next: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("ready not one cycle after access");
    a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
        else $error("read data outside answer cycle");
    c_fe_write: cover property (ctrl_wr && fes_ff);
    c_irq_up: cover property ($rose(irq_out));
    c_bad_addr: cover property (pslverr_out);
endmodule // usc_top_properties
bind usc_top usc_top_properties u_props (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .mode_out(mode_out),
    .rx_enable_out(rx_enable_out),
    .irq_out(irq_out)
);
`default_nettype wire

//--- verification/usc_top_tb.sv
// self-checking bench for the serial control and flag logic
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module usc_top_tb
    import usc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // harness
    // ************************************************************
    logic clk, rst, psel, pen, pwr, pready, pslverr, e, ren_o, mpe_o, tb8_o, irq, nv, sv;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0] mode;
    logic [5:0] ev;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    usc_top DUT (.sys_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .rx_bit8_done_in(ev[0]),
        .rx_ninth_mid_in(ev[1]), .rx_ninth_val_in(nv), .rx_stop_mid_in(ev[2]),
        .rx_stop_val_in(sv), .tx_bit8_done_in(ev[3]), .tx_stop_start_in(ev[4]),
        .tx_stop_end_in(ev[5]), .mode_out(mode), .rx_enable_out(ren_o),
        .multiproc_enable_out(mpe_o), .tx_ninth_bit_out(tb8_o), .irq_out(irq));
    usc_line_model u_line (.clk_in(clk), .evt_out(ev), .ninth_val_out(nv), .stop_val_out(sv));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            n_fail++;
            stop_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        `CHK(q & m, x)
    endtask
    // ************************************************************
    // tests
    // ************************************************************
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++)
            rd(8'(4 * i), 32'h0, 32'hffffffff);
        `CHK(mode, 2'h0)
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            wr(USC_OFS_CTRL, {24'h0, 2'(i), 6'h18});
            `CHK(mode, 2'(i))
            rd(USC_OFS_CTRL, {24'h0, 2'(i), 6'h18}, 32'hff);
        end
        `CHK({ren_o, tb8_o, mpe_o}, 3'h6)
        apb(1'b0, 8'h14, 32'h0);
        `CHK({e, q}, 33'h100000000)
        $display("test modes done");
        wr(USC_OFS_CTRL, 32'h40);
        u_line.frame(6'b000100, 1'b0, 1'b1);
        rd(USC_OFS_CTRL, 32'h40, 32'hff);
        wr(USC_OFS_IRQ_MASK, 32'h7);
        wr(USC_OFS_CTRL, 32'h50);
        u_line.frame(6'b000100, 1'b0, 1'b1);
        rd(USC_OFS_CTRL, 32'h55, 32'hff);
        wr(USC_OFS_CTRL, 32'h50);
        u_line.frame(6'b000100, 1'b1, 1'b0);
        rd(USC_OFS_CTRL, 32'h51, 32'hff);
        repeat (20) @(posedge clk);
        rd(USC_OFS_CTRL, 32'h51, 32'hff);
        `CHK(irq, 1'b1)
        wr(USC_OFS_IRQ_STAT, 32'h7);
        rd(USC_OFS_IRQ_STAT, 32'h0, 32'h7);
        `CHK(irq, 1'b0)
        $display("test async rx done");
        wr(USC_OFS_CTRL, 32'h10);
        u_line.frame(6'b001001, 1'b0, 1'b0);
        rd(USC_OFS_CTRL, 32'h13, 32'hfb);
        wr(USC_OFS_CTRL, 32'h40);
        u_line.frame(6'b100000, 1'b0, 1'b1);
        rd(USC_OFS_CTRL, 32'h40, 32'hff);
        u_line.frame(6'b010000, 1'b0, 1'b1);
        rd(USC_OFS_CTRL, 32'h42, 32'hff);
        wr(USC_OFS_STAT, 32'h40);
        wr(USC_OFS_CTRL, 32'h40);
        u_line.frame(6'b010000, 1'b0, 1'b1);
        rd(USC_OFS_CTRL, 32'h40, 32'hff);
        u_line.frame(6'b100000, 1'b0, 1'b1);
        rd(USC_OFS_CTRL, 32'h42, 32'hff);
        wr(USC_OFS_STAT, 32'h0);
        $display("test tx position done");
        wr(USC_OFS_CTRL, 32'hd0);
        u_line.frame(6'b000100, 1'b1, 1'b1);
        rd(USC_OFS_CTRL, 32'hd0, 32'hff);
        u_line.frame(6'b000010, 1'b1, 1'b1);
        rd(USC_OFS_CTRL, 32'hd5, 32'hff);
        wr(USC_OFS_CFG, 32'h40);
        wr(USC_OFS_CTRL, 32'h70);
        `CHK(mode, 2'h3)
        u_line.frame(6'b000010, 1'b1, 1'b1);
        rd(USC_OFS_CTRL, 32'h70, 32'hff);
        u_line.frame(6'b000100, 1'b0, 1'b1);
        rd(USC_OFS_CTRL, 32'h70, 32'hff);
        u_line.frame(6'b000100, 1'b1, 1'b0);
        rd(USC_OFS_CTRL, 32'hf5, 32'hff);
        `CHK(mode, 2'h3)
        rd(USC_OFS_STAT, 32'h08, 32'h08);
        $display("test nine-bit done");
        stop_test();
    end
endmodule // usc_top_tb
`default_nettype wire
